// *** mccd_fmem.sv ***
// Data memory of 512 bytes with registered read data
`timescale 1ns/1ps
module mccd_fmem (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Memory port
  mccd_mem_if.mem m
);
  logic [7:0] mem_ff [mccd_pkg::FDEPTH];
  logic [7:0] rdata_ff;

  always_ff @(posedge i_clk) begin
    if (m.we) begin
      mem_ff[m.addr] <= m.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_ff <= mccd_pkg::DATA_ZERO;
    end else begin
      rdata_ff <= m.we ? m.wdata : mem_ff[m.addr];
    end
  end

  assign m.rdata = rdata_ff;
endmodule

// *** mccd_mem_if.sv ***
// Interface between the executor and its data memory
`timescale 1ns/1ps
interface mccd_mem_if;
  logic [mccd_pkg::FADDR_W-1:0] addr;
  logic we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport master (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface

// *** mccd_monitor.sv ***
// Port checker for the instruction executor
`timescale 1ns/1ps
module mccd_monitor (
  // Watched ports
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic [4:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [31:0] O_AVS_READDATA,
  input wire logic O_AVS_WAITREQUEST
);
  logic [4:0] la_ff;
  logic [15:0] ld_ff;
  logic [3:0] pd_ff;
  logic [3:0] ag_ff;
  wire logic [4:0] ad = I_AVS_ADDRESS;
  wire logic [31:0] rd = O_AVS_READDATA;
  wire logic wok = I_AVS_WRITE && !O_AVS_WAITREQUEST;
  wire logic rok = I_AVS_READ && !O_AVS_WAITREQUEST;
  // Last write was an instruction not preceded by a bit test
  wire logic ins = la_ff == mccd_pkg::OFS_INSTR && pd_ff != 4'hF;
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      la_ff <= 5'h1F;
      ld_ff <= 16'h0000;
      pd_ff <= 4'h0;
      ag_ff <= 4'h0;
    end else if (wok) begin
      la_ff <= ad;
      ld_ff <= I_AVS_WRITEDATA[15:0];
      pd_ff <= ld_ff[13:10];
      ag_ff <= 4'h0;
    end else begin
      ag_ff <= ag_ff + {3'h0, ~&ag_ff};
    end
  end
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);
  a_skip_cycles:
    assert property (rok && ins && &ld_ff[13:10] &&
      ad == mccd_pkg::OFS_CYCLES |-> rd inside {32'h1, 32'h2})
      else $error("bit test cycles wrong");
  a_plain_cycles:
    assert property (rok && ins && !(&ld_ff[13:10]) &&
      ad == mccd_pkg::OFS_CYCLES |-> rd == 32'h1)
      else $error("cycles not one");
  a_clrf_zero:
    assert property (rok && ins && ld_ff[13:7] == 7'h03 &&
      ad == mccd_pkg::OFS_STATUS |-> rd[0]) else $error("zero not set");
  a_clra_acc:
    assert property (rok && ins && ld_ff == mccd_pkg::OP_CLEAR_ACC &&
      ad == mccd_pkg::OFS_ACC |-> rd == 32'h0) else $error("acc not clear");
  a_kick_wdog:
    assert property (rok && ins && ld_ff == mccd_pkg::OP_WATCHDOG_KICK &&
      ag_ff < 4'h8 && ad == mccd_pkg::OFS_WDOG |-> rd < 32'h8)
      else $error("watchdog not cleared");
  a_exec_once:
    assert property (wok && ad == mccd_pkg::OFS_INSTR |=> O_AVS_WAITREQUEST
      ##1 !(I_AVS_WRITE && O_AVS_WAITREQUEST)) else $error("busy too long");
  a_read_bound:
    assert property ($rose(I_AVS_READ) |-> O_AVS_WAITREQUEST ##[1:4]
      !O_AVS_WAITREQUEST) else $error("read answer late");
  a_gap_zero:
    assert property (rok && ad > 5'h18 |-> rd == 32'h0)
      else $error("unmapped read not zero");
  c_skip: cover property (rok && ad == mccd_pkg::OFS_CYCLES && rd == 32'h2);
  c_kick: cover property (ins && ld_ff == mccd_pkg::OP_WATCHDOG_KICK);
  c_fdata: cover property (rok && ad == mccd_pkg::OFS_FDATA);
endmodule
bind mccd_top mccd_monitor mon_u (.I_SYS_CLK, .I_RSTN, .I_AVS_ADDRESS,
  .I_AVS_READ, .I_AVS_WRITE, .I_AVS_WRITEDATA, .O_AVS_READDATA,
  .O_AVS_WAITREQUEST);

// *** mccd_pkg.sv ***
// Package with offsets, fields, opcodes and state types of the executor
package mccd_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_INSTR = 5'h00;
  localparam logic [4:0] OFS_ACC = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_CYCLES = 5'h0C;
  localparam logic [4:0] OFS_WDOG = 5'h10;
  localparam logic [4:0] OFS_FADDR = 5'h14;
  localparam logic [4:0] OFS_FDATA = 5'h18;
  // Status field positions
  localparam int ST_ZERO_BIT = 0;
  localparam int ST_TMO_BIT = 1;
  localparam int ST_PWD_BIT = 2;
  localparam int ST_SKIP_BIT = 3;
  localparam int ST_BUSY_BIT = 4;
  // Reset values and other constants
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] WDOG_RST = 8'h00;
  localparam logic [7:0] WDOG_LAST = 8'hFF;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [7:0] DATA_ONE = 8'h01;
  localparam logic [15:0] OP_RST = 16'h0000;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic ZERO_RST = 1'b0;
  localparam logic TMO_RST = 1'b1;
  localparam logic PWD_RST = 1'b1;
  localparam logic SKIP_RST = 1'b0;
  localparam logic [1:0] CYC_RST = 2'h0;
  localparam logic [8:0] FADDR_RST = 9'h000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  // Opcodes and opcode patterns
  localparam logic [15:0] OP_CLEAR_ACC = 16'h0140;
  localparam logic [15:0] OP_WATCHDOG_KICK = 16'h1E04;
  localparam logic [6:0] PAT_CLEAR_FILE = 7'h03;
  localparam logic [5:0] PAT_COMPLEMENT = 6'h09;
  localparam logic [5:0] PAT_DECREMENT = 6'h03;
  localparam logic [3:0] PAT_BIT_TEST_SET = 4'hF;
  // Widths
  localparam int FADDR_W = 9;
  localparam int FDEPTH = 512;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MRD,
    ST_RESP,
    ST_EXEC
  } mccd_state_e;

  typedef struct packed {
    mccd_state_e state;
    logic [7:0] acc;
    logic zero;
    logic tmo;
    logic pwd;
    logic skip;
    logic [1:0] cycles;
    logic [15:0] op;
    logic [7:0] wdog;
    logic [FADDR_W-1:0] faddr;
    logic [31:0] rdata;
  } mccd_regs_s;
endpackage

// *** mccd_top.sv ***
// Executor for clear, complement, decrement, bit test and watchdog ops
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
module mccd_top (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  // Avalon-MM slave
  input wire logic [4:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST
);
  mccd_pkg::mccd_regs_s cur_ff;
  mccd_pkg::mccd_regs_s nxt_regs;
  mccd_mem_if mem_bus ();

  mccd_fmem u_fmem (
    .i_clk (I_SYS_CLK),
    .i_rstn (I_RSTN),
    .m (mem_bus.mem)
  );

  // Instruction kinds that the executor tells apart
  typedef enum logic [2:0] {
    KIND_NOP,
    KIND_CLEAR_ACC,
    KIND_KICK,
    KIND_CLEAR_FILE,
    KIND_COMPLEMENT,
    KIND_DECREMENT,
    KIND_BIT_TEST
  } mccd_kind_e;

  mccd_kind_e kind;
  logic [7:0] bit_hit;
  logic bit_set;

  // Sort the held opcode; unknown codes run as a no-operation
  function automatic mccd_kind_e decode_kind(input logic [15:0] op);
    mccd_kind_e k;
    k = KIND_NOP;
    if (op == mccd_pkg::OP_CLEAR_ACC) begin
      k = KIND_CLEAR_ACC;
    end else if (op == mccd_pkg::OP_WATCHDOG_KICK) begin
      k = KIND_KICK;
    end else if (op[13:7] == mccd_pkg::PAT_CLEAR_FILE) begin
      k = KIND_CLEAR_FILE;
    end else if (op[13:8] == mccd_pkg::PAT_COMPLEMENT) begin
      k = KIND_COMPLEMENT;
    end else if (op[13:8] == mccd_pkg::PAT_DECREMENT) begin
      k = KIND_DECREMENT;
    end else if (op[13:10] == mccd_pkg::PAT_BIT_TEST_SET) begin
      k = KIND_BIT_TEST;
    end
    return k;
  endfunction

  assign kind = decode_kind(cur_ff.op);

  // Bit test: one select term per operand bit
  generate
    for (genvar gi = 0; gi < 8; gi++) begin : g_bit_sel
      assign bit_hit[gi] = mem_bus.rdata[gi] &&
                           (cur_ff.op[9:7] == 3'(gi));
    end
  endgenerate
  assign bit_set = |bit_hit;

  // Register read view
  function automatic logic [31:0] reg_view(
    input mccd_pkg::mccd_regs_s r,
    input logic [4:0] a
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      mccd_pkg::OFS_INSTR: v[15:0] = r.op;
      mccd_pkg::OFS_ACC: v[7:0] = r.acc;
      mccd_pkg::OFS_STATUS: begin
        v[mccd_pkg::ST_ZERO_BIT] = r.zero;
        v[mccd_pkg::ST_TMO_BIT] = r.tmo;
        v[mccd_pkg::ST_PWD_BIT] = r.pwd;
        v[mccd_pkg::ST_SKIP_BIT] = r.skip;
        v[mccd_pkg::ST_BUSY_BIT] = (r.state == mccd_pkg::ST_EXEC);
      end
      mccd_pkg::OFS_CYCLES: v[1:0] = r.cycles;
      mccd_pkg::OFS_WDOG: v[7:0] = r.wdog;
      mccd_pkg::OFS_FADDR: v[mccd_pkg::FADDR_W-1:0] = r.faddr;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_comb begin
    logic [mccd_pkg::FADDR_W-1:0] f_addr;
    logic [7:0] f_data;
    logic [7:0] res;
    logic res_valid;
    f_addr = {cur_ff.op[15:14], cur_ff.op[6:0]};
    f_data = mem_bus.rdata;
    res = mccd_pkg::DATA_ZERO;
    res_valid = 1'b0;
    nxt_regs = cur_ff;
    mem_bus.addr = cur_ff.faddr;
    mem_bus.we = 1'b0;
    mem_bus.wdata = mccd_pkg::DATA_ZERO;
    O_AVS_WAITREQUEST = 1'b1;
    // Watchdog counter runs every clock; wrap marks a timeout
    nxt_regs.wdog = cur_ff.wdog + mccd_pkg::DATA_ONE;
    if (cur_ff.wdog == mccd_pkg::WDOG_LAST) begin
      nxt_regs.tmo = 1'b0;
    end
    case (cur_ff.state)
      mccd_pkg::ST_IDLE: begin
        if (I_AVS_WRITE) begin
          O_AVS_WAITREQUEST = 1'b0;
          case (I_AVS_ADDRESS)
            mccd_pkg::OFS_INSTR: begin
              nxt_regs.op = I_AVS_WRITEDATA[15:0];
              // Fetch operand while the opcode is latched
              mem_bus.addr = {I_AVS_WRITEDATA[15:14],
                              I_AVS_WRITEDATA[6:0]};
              nxt_regs.state = mccd_pkg::ST_EXEC;
            end
            mccd_pkg::OFS_ACC: nxt_regs.acc = I_AVS_WRITEDATA[7:0];
            mccd_pkg::OFS_FADDR: begin
              nxt_regs.faddr = I_AVS_WRITEDATA[mccd_pkg::FADDR_W-1:0];
            end
            mccd_pkg::OFS_FDATA: begin
              mem_bus.we = 1'b1;
              mem_bus.wdata = I_AVS_WRITEDATA[7:0];
            end
            default: nxt_regs.state = mccd_pkg::ST_IDLE;
          endcase
        end else if (I_AVS_READ) begin
          if (I_AVS_ADDRESS == mccd_pkg::OFS_FDATA) begin
            nxt_regs.state = mccd_pkg::ST_MRD;
          end else begin
            nxt_regs.rdata = reg_view(cur_ff, I_AVS_ADDRESS);
            nxt_regs.state = mccd_pkg::ST_RESP;
          end
        end
      end
      mccd_pkg::ST_MRD: begin
        nxt_regs.rdata = {24'h00_0000, mem_bus.rdata};
        nxt_regs.state = mccd_pkg::ST_RESP;
      end
      mccd_pkg::ST_RESP: begin
        O_AVS_WAITREQUEST = 1'b0;
        nxt_regs.state = mccd_pkg::ST_IDLE;
      end
      mccd_pkg::ST_EXEC: begin
        mem_bus.addr = f_addr;
        nxt_regs.cycles = mccd_pkg::CYC_ONE;
        nxt_regs.state = mccd_pkg::ST_IDLE;
        if (cur_ff.skip) begin
          // Discarded instruction runs as a no-operation
          nxt_regs.skip = 1'b0;
        end else if (kind == KIND_CLEAR_ACC) begin
          nxt_regs.acc = mccd_pkg::DATA_ZERO;
          nxt_regs.zero = 1'b1;
        end else if (kind == KIND_KICK) begin
          nxt_regs.wdog = mccd_pkg::WDOG_RST;
          nxt_regs.tmo = 1'b1;
          nxt_regs.pwd = 1'b1;
        end else if (kind == KIND_CLEAR_FILE) begin
          mem_bus.we = 1'b1;
          mem_bus.wdata = mccd_pkg::DATA_ZERO;
          nxt_regs.zero = 1'b1;
        end else if (kind == KIND_COMPLEMENT) begin
          res = ~f_data;
          res_valid = 1'b1;
        end else if (kind == KIND_DECREMENT) begin
          res = f_data - mccd_pkg::DATA_ONE;
          res_valid = 1'b1;
        end else if (kind == KIND_BIT_TEST) begin
          if (bit_set) begin
            nxt_regs.skip = 1'b1;
            nxt_regs.cycles = mccd_pkg::CYC_TWO;
          end
        end
        if (res_valid) begin
          nxt_regs.zero = (res == mccd_pkg::DATA_ZERO);
          if (cur_ff.op[7]) begin
            mem_bus.we = 1'b1;
            mem_bus.wdata = res;
          end else begin
            nxt_regs.acc = res;
          end
        end
      end
      default: nxt_regs.state = mccd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cur_ff.state <= mccd_pkg::ST_IDLE;
      cur_ff.acc <= mccd_pkg::ACC_RST;
      cur_ff.zero <= mccd_pkg::ZERO_RST;
      cur_ff.tmo <= mccd_pkg::TMO_RST;
      cur_ff.pwd <= mccd_pkg::PWD_RST;
      cur_ff.skip <= mccd_pkg::SKIP_RST;
      cur_ff.cycles <= mccd_pkg::CYC_RST;
      cur_ff.op <= mccd_pkg::OP_RST;
      cur_ff.wdog <= mccd_pkg::WDOG_RST;
      cur_ff.faddr <= mccd_pkg::FADDR_RST;
      cur_ff.rdata <= mccd_pkg::RDATA_RST;
    end else begin
      cur_ff <= nxt_regs;
    end
  end

  assign O_AVS_READDATA = cur_ff.rdata;
endmodule

// *** mccd_top_tb.sv ***
// Testbench running instructions through the register bus
`timescale 1ns/1ps
module mccd_top_tb;
  localparam logic [4:0] r_in = mccd_pkg::OFS_INSTR;
  localparam logic [4:0] r_acc = mccd_pkg::OFS_ACC;
  localparam logic [4:0] r_st = mccd_pkg::OFS_STATUS;
  localparam logic [4:0] r_cy = mccd_pkg::OFS_CYCLES;
  localparam logic [4:0] r_fa = mccd_pkg::OFS_FADDR;
  localparam logic [4:0] r_fd = mccd_pkg::OFS_FDATA;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rd_r = 1'b0;
  logic wr_r = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic wq;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  mccd_top dut_u (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_AVS_ADDRESS(adr),
    .I_AVS_READ(rd_r), .I_AVS_WRITE(wr_r), .I_AVS_WRITEDATA(wd),
    .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wq));
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] s, e, input string n);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    adr <= a;
    wd <= {16'h0000, d};
    wr_r <= 1'b1;
    do @(posedge clk); while (wq);
    wr_r <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input string n);
    adr <= a;
    rd_r <= 1'b1;
    do @(posedge clk); while (wq);
    q = rdat;
    rd_r <= 1'b0;
    chk(q, e, n);
    @(posedge clk);
  endtask
  // Run one instruction, then check its result and the zero flag
  task automatic ex(input logic [15:0] op, input logic [4:0] a,
    input logic [7:0] e, input logic [31:0] st);
    wr(r_in, op);
    rd(a, {24'h0, e}, "result");
    rd(r_st, st, "status");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(r_acc, 32'h0, "acc");
    rd(r_st, 32'h6, "status");
    rd(5'h1C, 32'h0, "gap");
    wr(r_acc, 16'h005A);
    ex(mccd_pkg::OP_CLEAR_ACC, r_acc, 8'h00, 32'h7);
    rd(r_cy, 32'h1, "cycles");
    wr(r_fa, 16'h01FF);
    wr(r_fd, 16'h005A);
    ex(16'hC1FF, r_fd, 8'h00, 32'h7);
    wr(r_fa, 16'h0013);
    wr(r_fd, 16'h0013);
    ex(16'h0913, r_acc, 8'hEC, 32'h6);
    ex(16'h0993, r_fd, 8'hEC, 32'h6);
    wr(r_fd, 16'h00FF);
    ex(16'h0913, r_acc, 8'h00, 32'h7);
    wr(r_fd, 16'h0001);
    ex(16'h0393, r_fd, 8'h00, 32'h7);
    ex(16'h0393, r_fd, 8'hFF, 32'h6);
    ex(16'h0313, r_acc, 8'hFE, 32'h6);
    wr(r_fd, 16'h0002);
    wr(r_in, 16'h3C93);
    rd(r_cy, 32'h2, "cycles");
    rd(r_st, 32'hE, "status");
    ex(mccd_pkg::OP_CLEAR_ACC, r_acc, 8'hFE, 32'h6);
    rd(r_cy, 32'h1, "cycles");
    wr(r_in, 16'h3C13);
    rd(r_cy, 32'h1, "cycles");
    ex(mccd_pkg::OP_CLEAR_ACC, r_acc, 8'h00, 32'h7);
    repeat (300) @(posedge clk);
    rd(r_st, 32'h5, "status");
    wr(r_in, mccd_pkg::OP_WATCHDOG_KICK);
    wr(r_in, mccd_pkg::OP_WATCHDOG_KICK);
    rd(r_st, 32'h7, "status");
    adr <= mccd_pkg::OFS_WDOG;
    rd_r <= 1'b1;
    do @(posedge clk); while (wq);
    rd_r <= 1'b0;
    chk({3'h0, rdat[31:3]}, 32'h0, "wdog");
    print_verdict();
  end
endmodule
